// file: deor_regs.vh
// Register map, field positions and reset values of the drawing operand register bank
// Contract
// - a zero mask bit stops the carry out of that bit position
// - the carry mask governs arithmetic mixes and colour-compare evaluation alike
// - no carry ever leaves the most significant bit of a pel
// - mask and colours use only the low bits matching destination pel depth
// - stored foreground colour feeds the foreground operand when selected
// - stored background colour feeds the background operand when selected
// - first dimension holds width or line length minus one
// - second dimension holds rectangle height minus one
// - mask map origin offsets are relative to destination map origin
// - source X and Y hold the current source pel, read and write
// - pattern X and Y hold the current pattern pel, read and write
// - destination X and Y hold signed current destination pel, read and write
// - mask, colour, dimension and offset registers are write-only
// - foreground selector 00 picks foreground colour, 10 the source pel map
// - background selector 00 picks background colour, 10 the source pel map
`ifndef DEOR_REGS_VH
`define DEOR_REGS_VH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------------
`define DEOR_IDX_CARRY      8'h54
`define DEOR_IDX_FORE       8'h58
`define DEOR_IDX_BACK       8'h5C
`define DEOR_IDX_DIM1       8'h60
`define DEOR_IDX_DIM2       8'h62
`define DEOR_IDX_STEN_X     8'h6C
`define DEOR_IDX_STEN_Y     8'h6E
`define DEOR_IDX_SRC_X      8'h70
`define DEOR_IDX_SRC_Y      8'h72
`define DEOR_IDX_PAT_X      8'h74
`define DEOR_IDX_PAT_Y      8'h76
`define DEOR_IDX_DST_X      8'h78
`define DEOR_IDX_DST_Y      8'h7A
`define DEOR_IDX_OPCTL      8'h7C
`define DEOR_IDX_DEPTH      8'h80

// ----------------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------------
`define DEOR_AW             10
`define DEOR_IDX_W          8
`define DEOR_DW             32
`define DEOR_HW             16

// ----------------------------------------------------------------------------
// Operation control fields
// ----------------------------------------------------------------------------
`define DEOR_BS_HI          31
`define DEOR_BS_LO          30
`define DEOR_FS_HI          29
`define DEOR_FS_LO          28
`define DEOR_SEL_COLOUR     2'h0
`define DEOR_SEL_SRCMAP     2'h2
`define DEOR_DEPTH_HI       2
`define DEOR_DEPTH_LO       0

// ----------------------------------------------------------------------------
// Pel depth codes
// ----------------------------------------------------------------------------
`define DEOR_DEPTH_1        3'h0
`define DEOR_DEPTH_2        3'h1
`define DEOR_DEPTH_4        3'h2
`define DEOR_DEPTH_8        3'h3
`define DEOR_DEPTH_16       3'h4
`define DEOR_DEPTH_32       3'h5

// ----------------------------------------------------------------------------
// Coordinate update selectors from the engine
// ----------------------------------------------------------------------------
`define DEOR_CSEL_SRC_X     3'h0
`define DEOR_CSEL_SRC_Y     3'h1
`define DEOR_CSEL_PAT_X     3'h2
`define DEOR_CSEL_PAT_Y     3'h3
`define DEOR_CSEL_DST_X     3'h4
`define DEOR_CSEL_DST_Y     3'h5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DEOR_RST_WORD       32'h0000_0000
`define DEOR_RST_HALF       16'h0000
`define DEOR_RST_DEPTH      3'h3
`define DEOR_RST_SEL        2'h0
`define DEOR_RST_CNT        17'h0_0001
`define DEOR_ONE_CNT        17'h0_0001

`endif

// file: deor_carry_add.v
// Pel adder whose carry chain is split by a mask and cut at the pel's top bit
`default_nettype none

module deor_carry_add (
  input  wire [31:0] a,
  input  wire [31:0] b,
  input  wire [31:0] carry_mask,
  input  wire [31:0] depth_mask,
  input  wire        carry_in,
  output reg  [31:0] sum
);

  reg [32:0] c;
  integer    i;

  // --------------------------------------------------------------------------
  // Section-wise ripple: each section restarts from carry_in
  // --------------------------------------------------------------------------
  always @* begin
    c   = 33'h0_0000_0000;
    sum = 32'h0000_0000;
    c[0] = carry_in;
    for (i = 0; i < 32; i = i + 1) begin
      sum[i] = (a[i] ^ b[i] ^ c[i]) & depth_mask[i];
      if (i < 31) begin
        if (carry_mask[i] && depth_mask[i + 1]) begin
          c[i + 1] = (a[i] & b[i]) | (a[i] & c[i]) | (b[i] & c[i]);
        end else begin
          c[i + 1] = carry_in;
        end
      end
    end
  end

endmodule // deor_carry_add

`default_nettype wire

// file: deor_regbank.v
// Operand and coordinate register bank of the drawing engine, Avalon-MM slave
`include "deor_regs.vh"
`default_nettype none

module deor_regbank (
  input  wire        mclk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Engine coordinate write-back
  input  wire        eng_coord_we,
  input  wire [2:0]  eng_coord_sel,
  input  wire [15:0] eng_coord_data,
  // Engine pel data
  input  wire [31:0] eng_dst_pel,
  input  wire [31:0] eng_src_pel,
  input  wire        eng_pattern_bit,
  // Operands to the engine
  output reg  [31:0] fore_operand,
  output reg  [31:0] back_operand,
  output reg  [31:0] carry_mask_eff,
  output reg  [31:0] mix_sum,
  output reg  [31:0] cmp_diff,
  output reg         cmp_equal,
  output reg  [16:0] width_pels,
  output reg  [16:0] height_rows,
  output reg  [15:0] stencil_x,
  output reg  [15:0] stencil_y,
  output reg  [15:0] src_x,
  output reg  [15:0] src_y,
  output reg  [15:0] pat_x,
  output reg  [15:0] pat_y,
  output reg  [15:0] dst_x,
  output reg  [15:0] dst_y
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [31:0] carry_split_mask;
  reg [31:0] fore_colour_value;
  reg [31:0] back_colour_value;
  reg [15:0] width_or_length;
  reg [15:0] rect_height;
  reg [15:0] stencil_origin_x;
  reg [15:0] stencil_origin_y;
  reg [15:0] src_coord_x;
  reg [15:0] src_coord_y;
  reg [15:0] pat_coord_x;
  reg [15:0] pat_coord_y;
  reg [15:0] dst_coord_x;
  reg [15:0] dst_coord_y;
  // Source selectors from operation control and pel depth from its own register: the state this bank needs
  reg [1:0]  fore_source_select;
  reg [1:0]  back_source_select;
  reg [2:0]  pel_depth_code;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [31:0] depth_to_mask;
    input [2:0] code;
    begin
      case (code)
        `DEOR_DEPTH_1:  depth_to_mask = 32'h0000_0001;
        `DEOR_DEPTH_2:  depth_to_mask = 32'h0000_0003;
        `DEOR_DEPTH_4:  depth_to_mask = 32'h0000_000F;
        `DEOR_DEPTH_8:  depth_to_mask = 32'h0000_00FF;
        `DEOR_DEPTH_16: depth_to_mask = 32'h0000_FFFF;
        // Codes above 16 bits per pel all give the full word
        default:        depth_to_mask = 32'hFFFF_FFFF;
      endcase
    end
  endfunction

  function [31:0] merge_word;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    begin
      merge_word[7:0]   = be[0] ? new_val[7:0]   : old_val[7:0];
      merge_word[15:8]  = be[1] ? new_val[15:8]  : old_val[15:8];
      merge_word[23:16] = be[2] ? new_val[23:16] : old_val[23:16];
      merge_word[31:24] = be[3] ? new_val[31:24] : old_val[31:24];
    end
  endfunction

  function [15:0] merge_half;
    input [15:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    begin
      merge_half[7:0]  = be[0] ? new_val[7:0]  : old_val[7:0];
      merge_half[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  function [31:0] pick_operand;
    input [1:0]  sel;
    input [31:0] colour;
    input [31:0] srcmap;
    input [31:0] dmask;
    begin
      // Reserved selector codes fall back to the stored colour
      if (sel == `DEOR_SEL_SRCMAP) begin
        pick_operand = srcmap & dmask;
      end else begin
        pick_operand = colour & dmask;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire [7:0] idx;
  wire       req;
  wire       wr_go;
  wire [31:0] dmask;

  assign idx   = avs_address[9:2];
  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & ~avs_waitrequest;
  // Depth mask confines every operand to the destination pel width
  assign dmask = depth_to_mask(pel_depth_code);

  reg [31:0] next_readdata;

  always @* begin
    case (idx)
      `DEOR_IDX_SRC_X: next_readdata = {16'h0000, src_coord_x};
      `DEOR_IDX_SRC_Y: next_readdata = {16'h0000, src_coord_y};
      `DEOR_IDX_PAT_X: next_readdata = {16'h0000, pat_coord_x};
      `DEOR_IDX_PAT_Y: next_readdata = {16'h0000, pat_coord_y};
      `DEOR_IDX_DST_X: next_readdata = {16'h0000, dst_coord_x};
      `DEOR_IDX_DST_Y: next_readdata = {16'h0000, dst_coord_y};
      `DEOR_IDX_DEPTH: next_readdata = {29'h0000_0000, pel_depth_code};
      default:         next_readdata = `DEOR_RST_WORD;
    endcase
  end

  // --------------------------------------------------------------------------
  // Handshake: wait one cycle, then answer for one cycle
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `DEOR_RST_WORD;
    end else if (req && avs_waitrequest) begin
      // A fixed single wait state lets read data come straight from a register
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= next_readdata;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Software-written registers; values hold until rewritten
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      carry_split_mask   <= `DEOR_RST_WORD;
      fore_colour_value  <= `DEOR_RST_WORD;
      back_colour_value  <= `DEOR_RST_WORD;
      width_or_length    <= `DEOR_RST_HALF;
      rect_height        <= `DEOR_RST_HALF;
      stencil_origin_x   <= `DEOR_RST_HALF;
      stencil_origin_y   <= `DEOR_RST_HALF;
      fore_source_select <= `DEOR_RST_SEL;
      back_source_select <= `DEOR_RST_SEL;
      pel_depth_code     <= `DEOR_RST_DEPTH;
    end else if (wr_go) begin
      case (idx)
        `DEOR_IDX_CARRY:  carry_split_mask  <= merge_word(carry_split_mask, avs_writedata, avs_byteenable);
        `DEOR_IDX_FORE:   fore_colour_value <= merge_word(fore_colour_value, avs_writedata, avs_byteenable);
        `DEOR_IDX_BACK:   back_colour_value <= merge_word(back_colour_value, avs_writedata, avs_byteenable);
        `DEOR_IDX_DIM1:   width_or_length   <= merge_half(width_or_length, avs_writedata, avs_byteenable);
        `DEOR_IDX_DIM2:   rect_height       <= merge_half(rect_height, avs_writedata, avs_byteenable);
        `DEOR_IDX_STEN_X: stencil_origin_x  <= merge_half(stencil_origin_x, avs_writedata, avs_byteenable);
        `DEOR_IDX_STEN_Y: stencil_origin_y  <= merge_half(stencil_origin_y, avs_writedata, avs_byteenable);
        `DEOR_IDX_OPCTL: begin
          if (avs_byteenable[3]) begin
            fore_source_select <= avs_writedata[`DEOR_FS_HI:`DEOR_FS_LO];
            back_source_select <= avs_writedata[`DEOR_BS_HI:`DEOR_BS_LO];
          end
        end
        `DEOR_IDX_DEPTH: begin
          if (avs_byteenable[0]) begin
            pel_depth_code <= avs_writedata[`DEOR_DEPTH_HI:`DEOR_DEPTH_LO];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Coordinates: software writes, engine write-back takes priority
  // --------------------------------------------------------------------------
  function coord_hit;
    input       sw_hit;
    input [2:0] sel;
    input [2:0] mine;
    begin
      // The engine carries the live position, so it wins a same-cycle collision
      coord_hit = sw_hit & ~(eng_coord_we & (sel == mine));
    end
  endfunction

  always @(posedge mclk) begin
    if (rst) begin
      src_coord_x <= `DEOR_RST_HALF;
      src_coord_y <= `DEOR_RST_HALF;
      pat_coord_x <= `DEOR_RST_HALF;
      pat_coord_y <= `DEOR_RST_HALF;
      dst_coord_x <= `DEOR_RST_HALF;
      dst_coord_y <= `DEOR_RST_HALF;
    end else begin
      if (eng_coord_we) begin
        case (eng_coord_sel)
          `DEOR_CSEL_SRC_X: src_coord_x <= eng_coord_data;
          `DEOR_CSEL_SRC_Y: src_coord_y <= eng_coord_data;
          `DEOR_CSEL_PAT_X: pat_coord_x <= eng_coord_data;
          `DEOR_CSEL_PAT_Y: pat_coord_y <= eng_coord_data;
          `DEOR_CSEL_DST_X: dst_coord_x <= eng_coord_data;
          `DEOR_CSEL_DST_Y: dst_coord_y <= eng_coord_data;
          default: begin
          end
        endcase
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_SRC_X, eng_coord_sel, `DEOR_CSEL_SRC_X)) begin
        src_coord_x <= merge_half(src_coord_x, avs_writedata, avs_byteenable);
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_SRC_Y, eng_coord_sel, `DEOR_CSEL_SRC_Y)) begin
        src_coord_y <= merge_half(src_coord_y, avs_writedata, avs_byteenable);
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_PAT_X, eng_coord_sel, `DEOR_CSEL_PAT_X)) begin
        pat_coord_x <= merge_half(pat_coord_x, avs_writedata, avs_byteenable);
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_PAT_Y, eng_coord_sel, `DEOR_CSEL_PAT_Y)) begin
        pat_coord_y <= merge_half(pat_coord_y, avs_writedata, avs_byteenable);
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_DST_X, eng_coord_sel, `DEOR_CSEL_DST_X)) begin
        dst_coord_x <= merge_half(dst_coord_x, avs_writedata, avs_byteenable);
      end
      if (coord_hit(wr_go && idx == `DEOR_IDX_DST_Y, eng_coord_sel, `DEOR_CSEL_DST_Y)) begin
        dst_coord_y <= merge_half(dst_coord_y, avs_writedata, avs_byteenable);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Operand selection and split-carry arithmetic
  // --------------------------------------------------------------------------
  wire [31:0] next_fore;
  wire [31:0] next_back;
  wire [31:0] mix_operand;
  wire [31:0] next_sum;
  wire [31:0] next_diff;
  wire [31:0] eff_mask;
  wire [31:0] dst_masked;

  assign next_fore   = pick_operand(fore_source_select, fore_colour_value, eng_src_pel, dmask);
  assign next_back   = pick_operand(back_source_select, back_colour_value, eng_src_pel, dmask);
  assign mix_operand = eng_pattern_bit ? next_fore : next_back;
  assign eff_mask    = carry_split_mask & dmask;
  assign dst_masked  = eng_dst_pel & dmask;

  deor_carry_add u_mix_add (
    .a          (dst_masked),
    .b          (mix_operand),
    .carry_mask (eff_mask),
    .depth_mask (dmask),
    .carry_in   (1'b0),
    .sum        (next_sum)
  );

  // Subtraction adds the inverted operand with a carry into every section
  deor_carry_add u_cmp_sub (
    .a          (dst_masked),
    .b          (~mix_operand),
    .carry_mask (eff_mask),
    .depth_mask (dmask),
    .carry_in   (1'b1),
    .sum        (next_diff)
  );

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      fore_operand   <= `DEOR_RST_WORD;
      back_operand   <= `DEOR_RST_WORD;
      carry_mask_eff <= `DEOR_RST_WORD;
      mix_sum        <= `DEOR_RST_WORD;
      cmp_diff       <= `DEOR_RST_WORD;
      cmp_equal      <= 1'b1;
      width_pels     <= `DEOR_RST_CNT;
      height_rows    <= `DEOR_RST_CNT;
      stencil_x      <= `DEOR_RST_HALF;
      stencil_y      <= `DEOR_RST_HALF;
      src_x          <= `DEOR_RST_HALF;
      src_y          <= `DEOR_RST_HALF;
      pat_x          <= `DEOR_RST_HALF;
      pat_y          <= `DEOR_RST_HALF;
      dst_x          <= `DEOR_RST_HALF;
      dst_y          <= `DEOR_RST_HALF;
    end else begin
      fore_operand   <= next_fore;
      back_operand   <= next_back;
      carry_mask_eff <= eff_mask;
      mix_sum        <= next_sum;
      cmp_diff       <= next_diff;
      cmp_equal      <= (next_diff == `DEOR_RST_WORD);
      width_pels     <= {1'b0, width_or_length} + `DEOR_ONE_CNT;
      height_rows    <= {1'b0, rect_height} + `DEOR_ONE_CNT;
      stencil_x      <= stencil_origin_x;
      stencil_y      <= stencil_origin_y;
      // Coordinate copies lag their registers by one clock
      src_x          <= src_coord_x;
      src_y          <= src_coord_y;
      pat_x          <= pat_coord_x;
      pat_y          <= pat_coord_y;
      dst_x          <= dst_coord_x;
      dst_y          <= dst_coord_y;
    end
  end

endmodule // deor_regbank

`default_nettype wire

// file: deor_regbank_sva.sv
// Port assertions for the drawing operand register bank
`default_nettype none

module deor_regbank_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        eng_coord_we,
  input wire logic [2:0]  eng_coord_sel,
  input wire logic [15:0] eng_coord_data,
  input wire logic [31:0] cmp_diff,
  input wire logic        cmp_equal,
  input wire logic [16:0] width_pels,
  input wire logic [16:0] height_rows,
  input wire logic [15:0] stencil_x,
  input wire logic [15:0] src_x,
  input wire logic [15:0] dst_y
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       wr_done;
  logic       wr_done_q;
  logic [7:0] idx;
  assign wr_done = avs_write && !avs_waitrequest;
  assign idx     = avs_address[9:2];
  always_ff @(posedge mclk) begin
    wr_done_q <= wr_done && !rst;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after a request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wo_zero: assert property (avs_read && !avs_waitrequest && ((idx >= 8'h54 && idx <= 8'h6E) || idx == 8'h7C)
    |-> avs_readdata == 32'h0000_0000)
    else $error("write-only location read nonzero");
  a_width_plus: assert property (wr_done && idx == 8'h60 && avs_byteenable[1:0] == 2'b11
    |=> ##1 width_pels == {1'b0, $past(avs_writedata[15:0], 2)} + 17'h0_0001)
    else $error("width not stored value plus one");
  a_height_plus: assert property (wr_done && idx == 8'h62 && avs_byteenable[1:0] == 2'b11 ##2 1'b1
    |-> height_rows - 17'h0_0001 == {1'b0, $past(avs_writedata[15:0], 2)})
    else $error("height not stored value plus one");
  a_stencil_copy: assert property (wr_done && idx == 8'h6C && avs_byteenable[1:0] == 2'b11 ##1 1'b1
    |=> stencil_x == $past(avs_writedata[15:0], 2))
    else $error("mask origin x not the written value");
  a_src_engine: assert property (eng_coord_we && eng_coord_sel == 3'h0 |=> ##1 src_x == $past(eng_coord_data, 2))
    else $error("engine source x update lost");
  a_dst_engine: assert property (eng_coord_we && eng_coord_sel == 3'h5 ##2 1'b1
    |-> dst_y == $past(eng_coord_data, 2))
    else $error("engine destination y update lost");
  a_size_hold: assert property (!wr_done && !wr_done_q |=> $stable(width_pels) && $stable(height_rows))
    else $error("dimension changed without a write");
  a_equal_flag: assert property (cmp_equal == (cmp_diff == 32'h0000_0000))
    else $error("compare flag disagrees with difference");
endmodule // deor_regbank_sva

bind deor_regbank deor_regbank_sva deor_regbank_sva_i (
  .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .eng_coord_we, .eng_coord_sel, .eng_coord_data, .cmp_diff, .cmp_equal,
  .width_pels, .height_rows, .stencil_x, .src_x, .dst_y
);
`default_nettype wire

// file: deor_regbank_bench.sv
// Self-checking bench for the drawing operand register bank
`default_nettype none

module deor_regbank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        eng_coord_we = 1'b0;
  logic [2:0]  eng_coord_sel = 3'h0;
  logic [15:0] eng_coord_data = 16'h0000;
  logic [31:0] eng_dst_pel = 32'h0000_0000;
  logic [31:0] eng_src_pel = 32'h0F0F_1E1E;
  logic        eng_pattern_bit = 1'b1;
  wire  [31:0] avs_readdata, fore_operand, back_operand, carry_mask_eff, mix_sum, cmp_diff;
  wire         avs_waitrequest, cmp_equal;
  wire  [16:0] width_pels, height_rows;
  wire  [15:0] stencil_x, stencil_y, src_x, src_y, pat_x, pat_y, dst_x, dst_y;
  int          bad_count = 0;
  int          check_count = 0;
  logic [31:0] rdata;
  logic [31:0] dmask;
  logic [15:0] cv [6] = '{16'h0FFF, 16'h0123, 16'h0000, 16'h0456, 16'hF800, 16'h17FF};
  logic [7:0]  wo [9] = '{8'h54, 8'h58, 8'h5C, 8'h60, 8'h62, 8'h64, 8'h6C, 8'h6E, 8'h7C};

  always #20 mclk = ~mclk;

  deor_regbank deor_regbank_i (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .eng_coord_we, .eng_coord_sel, .eng_coord_data, .eng_dst_pel, .eng_src_pel,
    .eng_pattern_bit, .fore_operand, .back_operand, .carry_mask_eff, .mix_sum, .cmp_diff, .cmp_equal,
    .width_pels, .height_rows, .stencil_x, .stencil_y, .src_x, .src_y, .pat_x, .pat_y, .dst_x, .dst_y
  );

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0) bad_count++;
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd, 4'hF);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0000_0000, 4'hF);
    chk("readdata", e, rdata);
  endtask

  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask

  task automatic op_case(input logic [31:0] m, input logic [31:0] dst, input logic pat,
                         input logic [31:0] sum, input logic [31:0] diff);
    wr(8'h54, m);
    eng_dst_pel <= dst;
    eng_pattern_bit <= pat;
    settle();
    chk("mix_sum", sum, mix_sum);
    chk("cmp_diff", diff, cmp_diff);
    chk("cmp_equal", {31'h0, diff == 32'h0}, {31'h0, cmp_equal});
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
    chk("sizes", 32'h0001_0001, {width_pels[15:0], height_rows[15:0]});
    rd(8'h80, 32'h0000_0003);
    for (int i = 0; i < 6; i++)
      wr(8'h70 + 8'(2 * i), {16'h0000, cv[i]});
    for (int i = 0; i < 6; i++)
      rd(8'h70 + 8'(2 * i), {16'h0000, cv[i]});
    chk("src xy", {cv[0], cv[1]}, {src_x, src_y});
    chk("pat xy", {cv[2], cv[3]}, {pat_x, pat_y});
    chk("dst xy", {cv[4], cv[5]}, {dst_x, dst_y});
    bus(1'b1, 8'h72, 32'hFFFF_BEEF, 4'h1);
    rd(8'h72, 32'h0000_01EF);
    wr(8'h54, 32'hFFFF_FFFF);
    wr(8'h60, 32'h0000_0FFF);
    wr(8'h62, 32'h0000_0009);
    wr(8'h6C, 32'h0000_0FFF);
    wr(8'h6E, 32'h0000_0ABC);
    wr(8'h64, 32'h0000_1111);
    for (int i = 0; i < 9; i++)
      rd(wo[i], 32'h0000_0000);
    chk("width", 32'h0000_1000, {15'h0, width_pels});
    chk("height", 32'h0000_000A, {15'h0, height_rows});
    chk("stencil", 32'h0FFF_0ABC, {stencil_x, stencil_y});
    wr(8'h60, 32'h0000_0009);
    wr(8'h62, 32'h0000_FFFF);
    settle();
    chk("width", 32'h0000_000A, {15'h0, width_pels});
    chk("height", 32'h0001_0000, {15'h0, height_rows});
    wr(8'h58, 32'hA5C3_5A3C);
    wr(8'h5C, 32'h1234_5678);
    for (int d = 0; d < 8; d++) begin
      wr(8'h80, 32'(d));
      dmask = (d > 4) ? 32'hFFFF_FFFF : (32'h1 << (1 << d)) - 32'h1;
      settle();
      chk("fore", 32'hA5C3_5A3C & dmask, fore_operand);
      chk("back", 32'h1234_5678 & dmask, back_operand);
      chk("carry", dmask, carry_mask_eff);
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h7C, {s[1:0], s[1:0], 28'h0});
      settle();
      chk("fore", (s == 2) ? eng_src_pel : 32'hA5C3_5A3C, fore_operand);
      chk("back", (s == 2) ? eng_src_pel : 32'h1234_5678, back_operand);
    end
    wr(8'h58, 32'h0000_0001);
    wr(8'h5C, 32'h0000_0001);
    op_case(32'hFFFF_FFFF, 32'h0000_FFFF, 1'b1, 32'h0001_0000, 32'h0000_FFFE);
    op_case(32'hFFFF_7FFF, 32'h0000_FFFF, 1'b0, 32'h0000_0000, 32'h0000_FFFE);
    op_case(32'hFFFF_7FFF, 32'h0001_0000, 1'b1, 32'h0001_0001, 32'h0001_FFFF);
    op_case(32'hFFFF_FFFF, 32'h0001_0000, 1'b1, 32'h0001_0001, 32'h0000_FFFF);
    op_case(32'hFFFF_FFFF, 32'h0000_0001, 1'b0, 32'h0000_0002, 32'h0000_0000);
    wr(8'h80, 32'h0000_0003);
    eng_dst_pel <= 32'h0000_00FF;
    settle();
    chk("mix_sum", 32'h0000_0000, mix_sum);
    eng_coord_we <= 1'b1;
    eng_coord_data <= 16'h0777;
    @(posedge mclk);
    eng_coord_sel <= 3'h6;
    eng_coord_data <= 16'hFFFF;
    @(posedge mclk);
    eng_coord_sel <= 3'h5;
    eng_coord_data <= 16'hF801;
    @(posedge mclk);
    eng_coord_we <= 1'b0;
    rd(8'h70, 32'h0000_0777);
    rd(8'h7A, 32'h0000_F801);
    chk("src xy", 32'h0777_01EF, {src_x, src_y});
    chk("pat xy", {cv[2], cv[3]}, {pat_x, pat_y});
    chk("dst xy", {cv[4], 16'hF801}, {dst_x, dst_y});
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
endmodule // deor_regbank_bench
`default_nettype wire
